// ==== hw/qed_pkg.sv ====
// constants shared by the encoder input decoder
package qed_pkg;
  localparam int POS_W = 32;
  localparam logic [31:0] POS_MAX_RST = 32'hffffffff;
  localparam logic [31:0] POS_ZERO = 32'h00000000;
  // input mode select codes
  localparam logic [1:0] MODE_QUAD = 2'h0;
  localparam logic [1:0] MODE_DIRCNT = 2'h1;
  localparam logic [1:0] MODE_UP = 2'h2;
  localparam logic [1:0] MODE_DOWN = 2'h3;
  // index/strobe action select codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_INIT = 2'h1;
  localparam logic [1:0] ACT_LATCH = 2'h2;
  localparam logic [1:0] ACT_RESET = 2'h3;
  // event edge select codes
  localparam logic EDGE_RISE = 1'b0;
  localparam logic EDGE_FALL = 1'b1;
  localparam int SYNC_STAGES = 2;
endpackage

// ==== hw/qed_decoder.sv ====
// encoder input decoder with position counter and index/strobe actions
//
// Functional notes
// - A leading B counts forward, else reverse
// - quadrature mode derives count clock and direction
// - both edges of both channels count, 4x
// - direction-count mode: A is clock, B direction
// - index can reset counter once per revolution
// - index event can initialise or latch counter
// - strobe event can initialise or latch counter
// - clock rising edge counts up/down by direction
// - in quadrature mode, simultaneous edges on both channels flag phase error
// - counter wraps at zero and maximum, flagged
// - in quadrature mode, exchange bit swaps channels, reversing count
`timescale 1ns/1ps

module qed_decoder
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic ENC_PHASE_A_I,
  input wire logic ENC_PHASE_B_I,
  input wire logic INDEX_INPUT_I,
  input wire logic STROBE_INPUT_I,
  input wire logic [1:0] MODE_SEL_I,
  input wire logic SWAP_I,
  input wire logic [1:0] INDEX_ACT_I,
  input wire logic INDEX_EDGE_I,
  input wire logic [1:0] STROBE_ACT_I,
  input wire logic STROBE_EDGE_I,
  input wire logic [qed_pkg::POS_W-1:0] POS_MAX_I,
  input wire logic [qed_pkg::POS_W-1:0] POS_INIT_I,
  input wire logic FLAG_CLR_I,
  output logic QUAD_COUNT_CLOCK_O,
  output logic COUNT_DIRECTION_O,
  output logic [qed_pkg::POS_W-1:0] POS_COUNT_O,
  output logic [qed_pkg::POS_W-1:0] INDEX_LATCH_O,
  output logic [qed_pkg::POS_W-1:0] STROBE_LATCH_O,
  output logic PHASE_ERROR_FLAG_O,
  output logic OVERFLOW_FLAG_O,
  output logic UNDERFLOW_FLAG_O
);
  import qed_pkg::*;

  // ==========================================================
  // input synchronisers and edge history
  // ==========================================================
  logic [3:0] meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;
  logic [3:0] rise, fall;

  always_comb begin
    meta_d = {STROBE_INPUT_I, INDEX_INPUT_I, ENC_PHASE_B_I, ENC_PHASE_A_I};
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
      prev_q <= 4'h0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

  // ==========================================================
  // decoder: count enable and direction
  // ==========================================================
  logic qa, qb, qa_p, qb_p, ea, eb;
  logic cnt_en, dir_d, dir_q, phe_ev;

  always_comb begin
    // swap exchanges channel roles ahead of decoding
    qa = SWAP_I ? sync_q[1] : sync_q[0];
    qb = SWAP_I ? sync_q[0] : sync_q[1];
    qa_p = SWAP_I ? prev_q[1] : prev_q[0];
    qb_p = SWAP_I ? prev_q[0] : prev_q[1];
    ea = qa ^ qa_p;
    eb = qb ^ qb_p;
    cnt_en = 1'b0;
    dir_d = dir_q;
    phe_ev = 1'b0;
    unique case (MODE_SEL_I)
      MODE_QUAD: begin
        cnt_en = (ea ^ eb);
        phe_ev = ea & eb;
        // forward when A edge makes A != B, i.e. A leads
        if (ea && !eb) begin
          dir_d = (qa != qb);
        end else if (eb && !ea) begin
          dir_d = (qa == qb);
        end
      end
      MODE_DIRCNT: begin
        cnt_en = rise[0];
        dir_d = sync_q[1];
      end
      MODE_UP: begin
        cnt_en = rise[0];
        dir_d = 1'b1;
      end
      MODE_DOWN: begin
        cnt_en = rise[0];
        dir_d = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // position counter, latches and flags
  // ==========================================================
  logic idx_ev, stb_ev;
  logic [POS_W-1:0] pos_q, pos_d, ilat_q, ilat_d, slat_q, slat_d;
  logic phe_q, phe_d, ovf_q, ovf_d, unf_q, unf_d, quad_count_clock_q, quad_count_clock_d;
  logic ovf_ev, unf_ev;

  assign idx_ev = INDEX_EDGE_I ? fall[2] : rise[2];
  assign stb_ev = STROBE_EDGE_I ? fall[3] : rise[3];

  always_comb begin
    pos_d = pos_q;
    ilat_d = ilat_q;
    slat_d = slat_q;
    ovf_ev = 1'b0;
    unf_ev = 1'b0;
    quad_count_clock_d = cnt_en;
    if (cnt_en) begin
      if (dir_d) begin
        if (pos_q >= POS_MAX_I) begin
          pos_d = POS_ZERO;
          ovf_ev = 1'b1;
        end else begin
          pos_d = pos_q + 1'b1;
        end
      end else if (pos_q == POS_ZERO) begin
        pos_d = POS_MAX_I;
        unf_ev = 1'b1;
      end else begin
        pos_d = pos_q - 1'b1;
      end
    end
    // strobe first so index wins a tie on counter load
    if (stb_ev) begin
      unique case (STROBE_ACT_I)
        ACT_INIT: pos_d = POS_INIT_I;
        ACT_LATCH: slat_d = pos_q;
        ACT_RESET: pos_d = dir_d ? POS_ZERO : POS_MAX_I;
        ACT_NONE: ;
      endcase
    end
    if (idx_ev) begin
      unique case (INDEX_ACT_I)
        ACT_INIT: pos_d = POS_INIT_I;
        ACT_LATCH: ilat_d = pos_q;
        // per-revolution reset, direction chooses zero or max
        ACT_RESET: pos_d = dir_d ? POS_ZERO : POS_MAX_I;
        ACT_NONE: ;
      endcase
    end
    // set beats clear for sticky flags
    phe_d = phe_ev | (phe_q & ~FLAG_CLR_I);
    ovf_d = ovf_ev | (ovf_q & ~FLAG_CLR_I);
    unf_d = unf_ev | (unf_q & ~FLAG_CLR_I);
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      pos_q <= POS_ZERO;
      ilat_q <= POS_ZERO;
      slat_q <= POS_ZERO;
      dir_q <= 1'b1;
      quad_count_clock_q <= 1'b0;
      phe_q <= 1'b0;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      pos_q <= pos_d;
      ilat_q <= ilat_d;
      slat_q <= slat_d;
      dir_q <= dir_d;
      quad_count_clock_q <= quad_count_clock_d;
      phe_q <= phe_d;
      ovf_q <= ovf_d;
      unf_q <= unf_d;
    end
  end

  assign QUAD_COUNT_CLOCK_O = quad_count_clock_q;
  assign COUNT_DIRECTION_O = dir_q;
  assign POS_COUNT_O = pos_q;
  assign INDEX_LATCH_O = ilat_q;
  assign STROBE_LATCH_O = slat_q;
  assign PHASE_ERROR_FLAG_O = phe_q;
  assign OVERFLOW_FLAG_O = ovf_q;
  assign UNDERFLOW_FLAG_O = unf_q;

  // ==========================================================
  // assertions
  // ==========================================================
  property p_quad_count_clock_pulse;
    @(posedge MCLK_I) disable iff (RST_I)
    cnt_en |=> QUAD_COUNT_CLOCK_O;
  endproperty
  a_quad_count_clock_pulse: assert property (p_quad_count_clock_pulse)
    else $error("count clock missing after count event");

  property p_quad_four;
    @(posedge MCLK_I) disable iff (RST_I)
    (MODE_SEL_I == MODE_QUAD && ((rise[0] | fall[0]) != (rise[1] | fall[1])))
      |-> cnt_en;
  endproperty
  a_quad_four: assert property (p_quad_four)
    else $error("single channel edge did not count");

  property p_fwd;
    @(posedge MCLK_I) disable iff (RST_I)
    (MODE_SEL_I == MODE_QUAD && !SWAP_I && rise[0] && !eb && !qb)
      |=> COUNT_DIRECTION_O;
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("A leading B not forward");

  property p_dircnt;
    @(posedge MCLK_I) disable iff (RST_I)
    (MODE_SEL_I == MODE_DIRCNT && rise[0])
      |=> (COUNT_DIRECTION_O == $past(sync_q[1]));
  endproperty
  a_dircnt: assert property (p_dircnt)
    else $error("direction input not followed");

  property p_dir_clk;
    @(posedge MCLK_I) disable iff (RST_I)
    (MODE_SEL_I == MODE_DIRCNT && !rise[0]) |-> !cnt_en;
  endproperty
  a_dir_clk: assert property (p_dir_clk)
    else $error("count without clock rising edge");

  property p_phe;
    @(posedge MCLK_I) disable iff (RST_I)
    (MODE_SEL_I == MODE_QUAD && ea && eb) |=> PHASE_ERROR_FLAG_O;
  endproperty
  a_phe: assert property (p_phe)
    else $error("phase error not flagged");

  property p_ovf;
    @(posedge MCLK_I) disable iff (RST_I)
    (cnt_en && dir_d && pos_q >= POS_MAX_I && !idx_ev && !stb_ev)
      |=> (POS_COUNT_O == POS_ZERO) && OVERFLOW_FLAG_O;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow wrap wrong");

  property p_idx_latch;
    @(posedge MCLK_I) disable iff (RST_I)
    (idx_ev && INDEX_ACT_I == ACT_LATCH)
      |=> (INDEX_LATCH_O == $past(pos_q));
  endproperty
  a_idx_latch: assert property (p_idx_latch)
    else $error("index latch wrong");

  property p_stb_init;
    @(posedge MCLK_I) disable iff (RST_I)
    (stb_ev && STROBE_ACT_I == ACT_INIT && !idx_ev)
      |=> (POS_COUNT_O == $past(POS_INIT_I));
  endproperty
  a_stb_init: assert property (p_stb_init)
    else $error("strobe init wrong");

  property p_idx_rst;
    @(posedge MCLK_I) disable iff (RST_I)
    (idx_ev && INDEX_ACT_I == ACT_RESET && dir_d) |=> POS_COUNT_O == POS_ZERO;
  endproperty
  a_idx_rst: assert property (p_idx_rst)
    else $error("index reset wrong");

  c_ovf: cover property (@(posedge MCLK_I) ovf_ev);
  c_unf: cover property (@(posedge MCLK_I) unf_ev);
  c_phe: cover property (@(posedge MCLK_I) phe_ev);
  c_swap: cover property (@(posedge MCLK_I) SWAP_I && cnt_en);
endmodule

// ==== bench/qed_enc_model.sv ====
// encoder and limit switch stand-in that drives the decoder pins
`timescale 1ns/1ps
module qed_enc_model (
  output logic enc_a_o,
  output logic enc_b_o,
  output logic index_o,
  output logic strobe_o
);
  // quarter of the 160 ns line period
  localparam time QTR = 40ns;
  int ph = 0;
  initial begin
    enc_a_o = 1'b0;
    enc_b_o = 1'b0;
    index_o = 1'b0;
    strobe_o = 1'b0;
  end
  // ==========================================
  // quadrature phases, a leads b going forward
  task automatic put(input int p, input logic idx);
    ph = p & 3;
    enc_a_o = (ph == 1) || (ph == 2);
    enc_b_o = (ph >= 2);
    index_o = idx;
    #QTR;
  endtask
  task automatic step(input logic fwd, input logic idx = 1'b0);
    put(fwd ? ph + 1 : ph + 3, idx);
  endtask
  // both channels at once, as a faulty encoder would
  task automatic glitch();
    put(ph + 2, 1'b0);
  endtask
  task automatic strobe();
    strobe_o = 1'b1;
    #QTR;
    strobe_o = 1'b0;
    #QTR;
  endtask
  // clock/direction source, direction set well before the edge
  task automatic dclk(input logic up);
    enc_b_o = up;
    #QTR;
    enc_a_o = 1'b1;
    #(2 * QTR);
    enc_a_o = 1'b0;
    #QTR;
  endtask
endmodule

// ==== bench/qed_decoder_test.sv ====
// self-checking bench for the encoder input decoder
`timescale 1ns/1ps
module qed_decoder_test;
  import qed_pkg::*;
  logic clk;
  logic rst;
  logic a, b, idx, stb, swap, fclr, iedge, sedge;
  logic [1:0] mode, iact, sact;
  logic [31:0] pmax, pinit;
  logic quad_count_clock, count_direction, perr, ovf, unf;
  logic [31:0] pos, ilat, slat;
  int n_fail = 0;
  int samples_checked = 0;
  int pulses = 0;
  always #5 clk = ~clk;
  always @(negedge clk) if (quad_count_clock === 1'b1) pulses++;
  qed_enc_model u_enc (.enc_a_o(a), .enc_b_o(b), .index_o(idx),
    .strobe_o(stb));
  qed_decoder DUT (.MCLK_I(clk), .RST_I(rst), .ENC_PHASE_A_I(a),
    .ENC_PHASE_B_I(b), .INDEX_INPUT_I(idx), .STROBE_INPUT_I(stb),
    .MODE_SEL_I(mode), .SWAP_I(swap), .INDEX_ACT_I(iact),
    .INDEX_EDGE_I(iedge), .STROBE_ACT_I(sact),
    .STROBE_EDGE_I(sedge), .POS_MAX_I(pmax),
    .POS_INIT_I(pinit), .FLAG_CLR_I(fclr),
    .QUAD_COUNT_CLOCK_O(quad_count_clock), .COUNT_DIRECTION_O(count_direction),
    .POS_COUNT_O(pos), .INDEX_LATCH_O(ilat), .STROBE_LATCH_O(slat),
    .PHASE_ERROR_FLAG_O(perr), .OVERFLOW_FLAG_O(ovf),
    .UNDERFLOW_FLAG_O(unf));
  // ==========================================
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic sync();
    @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================
  task automatic t_quad();
    sync();
    repeat (4) u_enc.step(1'b1);
    chk("pos", pos, 32'h00000004);
    chk("pulses", pulses, 4);
    chk("dir", count_direction, 1'b1);
    repeat (5) u_enc.step(1'b0);
    chk("pos", pos, 32'h0000000f);
    chk("dir", count_direction, 1'b0);
    chk("unf", unf, 1'b1);
    u_enc.step(1'b1);
    chk("pos", pos, 32'h00000000);
    chk("ovf", ovf, 1'b1);
  endtask
  task automatic t_err_swap();
    sync();
    fclr = 1'b1;
    sync();
    fclr = 1'b0;
    u_enc.glitch();
    chk("perr", perr, 1'b1);
    chk("pos", pos, 32'h00000000);
    swap = 1'b1;
    repeat (2) u_enc.step(1'b1);
    chk("pos", pos, 32'h0000000e);
    chk("dir", count_direction, 1'b0);
    swap = 1'b0;
  endtask
  task automatic t_dircnt();
    mode = MODE_DIRCNT;
    repeat (3) u_enc.dclk(1'b1);
    chk("pos", pos, 32'h00000001);
    u_enc.dclk(1'b0);
    chk("pos", pos, 32'h00000000);
    mode = MODE_QUAD;
  endtask
  task automatic t_events();
    sact = ACT_LATCH;
    repeat (3) u_enc.step(1'b1);
    u_enc.strobe();
    chk("slat", slat, 32'h00000003);
    sact = ACT_INIT;
    u_enc.strobe();
    chk("pos", pos, 32'h00000009);
    sact = ACT_NONE;
    iact = ACT_RESET;
    u_enc.step(1'b1, 1'b1);
    u_enc.step(1'b1);
    chk("pos", pos, 32'h00000001);
    iact = ACT_INIT;
    u_enc.step(1'b1, 1'b1);
    u_enc.step(1'b1);
    chk("pos", pos, 32'h0000000a);
  endtask
  task automatic t_more();
    iact = ACT_LATCH;
    iedge = EDGE_FALL;
    u_enc.step(1'b1, 1'b1);
    u_enc.step(1'b1);
    chk("ilat", ilat, 32'h0000000b);
    chk("pos", pos, 32'h0000000c);
    u_enc.step(1'b0);
    chk("dir", count_direction, 1'b0);
    iact = ACT_NONE;
    sact = ACT_RESET;
    sedge = EDGE_FALL;
    pmax = 32'h00000007;
    u_enc.strobe();
    chk("pos", pos, 32'h00000007);
    chk("ovf", ovf, 1'b1);
    chk("perr", perr, 1'b1);
    sync();
    fclr = 1'b1;
    sync();
    fclr = 1'b0;
    chk("perr", perr, 1'b0);
    chk("ovf", ovf, 1'b0);
    chk("unf", unf, 1'b0);
    // up mode ignores the low direction pin
    mode = MODE_UP;
    u_enc.dclk(1'b0);
    chk("pos", pos, 32'h00000000);
    chk("ovf", ovf, 1'b1);
    mode = MODE_DOWN;
    u_enc.dclk(1'b0);
    chk("pos", pos, 32'h00000007);
    chk("dir", count_direction, 1'b0);
    chk("unf", unf, 1'b1);
    mode = MODE_QUAD;
    sync();
    rst = 1'b1;
    sync();
    sync();
    rst = 1'b0;
    chk("pos", pos, 32'h00000000);
    chk("dir", count_direction, 1'b1);
    chk("ilat", ilat, 32'h00000000);
    chk("slat", slat, 32'h00000000);
    chk("quad_count_clock", quad_count_clock, 1'b0);
    chk("perr", perr, 1'b0);
    chk("ovf", ovf, 1'b0);
    chk("unf", unf, 1'b0);
    u_enc.step(1'b1);
    chk("pos", pos, 32'h00000001);
  endtask
  // ==========================================
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    swap = 1'b0;
    fclr = 1'b0;
    mode = MODE_QUAD;
    iact = ACT_NONE;
    sact = ACT_NONE;
    iedge = EDGE_RISE;
    sedge = EDGE_RISE;
    pmax = 32'h0000000f;
    pinit = 32'h00000009;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("pos", pos, 32'h00000000);
    chk("dir", count_direction, 1'b1);
    t_quad();
    t_err_swap();
    t_dircnt();
    t_events();
    t_more();
    print_verdict();
  end
  // whole sequence needs under 10 us
  initial begin
    #100us;
    n_fail++;
    print_verdict();
  end
endmodule
